// ---- io_bus_pkg.sv ----
/*
 * Constants shared by the processor end of the party-line I/O bus:
 * timing counts, instruction field positions, pin sampling layout.
 * Assumes the system clock runs at CLK_SYS_MHZ.
 */
package io_bus_pkg;
	localparam int CLK_SYS_MHZ = 50;
	localparam int BUS_CLK_KHZ = 5000;
	// System cycles per half period of the bus clock
	localparam int BUS_CLK_HALF = (CLK_SYS_MHZ * 1000) / (2 * BUS_CLK_KHZ);
	localparam int ADDR_SETUP_NS = 100;
	localparam int SYNC_WIDTH_NS = 400;
	localparam int QUEUE_SETTLE_NS = 600;
	localparam int QUEUE_GAP_NS = 200;
	localparam int IC_HOLD_NS = 10000;
	localparam int SETUP_CYC = (ADDR_SETUP_NS * CLK_SYS_MHZ + 999) / 1000;
	localparam int SYNC_CYC = (SYNC_WIDTH_NS * CLK_SYS_MHZ + 999) / 1000;
	localparam int SETTLE_CYC = (QUEUE_SETTLE_NS * CLK_SYS_MHZ + 999) / 1000;
	localparam int GAP_CYC = (QUEUE_GAP_NS * CLK_SYS_MHZ + 999) / 1000;
	localparam int IC_CYC = (IC_HOLD_NS * CLK_SYS_MHZ + 999) / 1000;
	localparam int CNT_W = 10;
	localparam int DIV_W = 3;
	// Instruction word: bit 0 is the least significant bit
	localparam int INSTR_ADDR_HI_MSB = 9;
	localparam int INSTR_ADDR_HI_LSB = 8;
	localparam int INSTR_ADDR_LO_MSB = 3;
	localparam int PRIO_USED = 8;
	// Sampled pin vector: {ic sources, source id, data, requests}
	localparam int REQ_LSB = 0;
	localparam int DATA_LSB = 3;
	localparam int SID_LSB = 19;
	localparam int ICS_LSB = 25;
	localparam int SYN_W = 28;
	localparam logic [SYN_W-1:0] SYN_RST = 28'h1ffffff;
	localparam logic [2:0] QUEUE_IDLE = 3'h7;
	typedef enum logic [1:0] {
		KIND_DMA,
		KIND_DATA_IRQ,
		KIND_SERVICE_IRQ
	} req_kind_e;
endpackage : io_bus_pkg

// ---- io_party_line_bus.sv ----
/*
 * Processor end of the party-line I/O bus: programmed transfers,
 * queue-update arbitration for the three request lines, bus clock and
 * initial-condition generation.
 * Assumes external drivers resolve the wired lines from the enables and
 * that the power and console sources are levels from another domain.
 */
`timescale 1ns/1ns
`default_nettype none
module io_party_line_bus
	import io_bus_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic io_req,
	input wire logic [15:0] io_instr,
	input wire logic io_is_data,
	input wire logic io_is_input,
	input wire logic [15:0] io_wdata,
	output logic io_ack,
	output logic [15:0] io_rdata,
	output logic grant_valid,
	output logic [1:0] grant_kind,
	output logic [5:0] grant_source_id,
	output logic [7:0] grant_prio,
	output logic grant_prio_unassigned,
	input wire logic grant_done,
	input wire logic power_fail,
	input wire logic power_restored,
	input wire logic master_clear_sw,
	output logic [5:0] dev_addr_n,
	output logic cmd_or_data_sel_n,
	output logic xfer_direction_n,
	output logic xfer_sync_n,
	output logic initial_condition,
	output logic bus_clock_5m_n,
	input wire logic [15:0] bus_data_i_n,
	output logic [15:0] bus_data_o_n,
	output logic bus_data_oe,
	input wire logic dma_word_request_n,
	input wire logic data_irq_request_n,
	input wire logic service_irq_request_n,
	output logic dma_queue_update_n,
	output logic data_irq_queue_update_n,
	output logic service_irq_queue_update_n,
	input wire logic [5:0] source_ident_i_n
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_SETUP, ST_SYNC, ST_HOLD, ST_QUEUE, ST_QGAP
	} bus_state_e;

	typedef struct packed {
		bus_state_e state;
		logic [CNT_W-1:0] cnt;
		logic [DIV_W-1:0] div;
		logic clk_n;
		logic [SYN_W-1:0] s1;
		logic [SYN_W-1:0] s2;
		logic [SYN_W-1:0] s3;
		logic [SYN_W-1:0] stab;
		logic [2:0] ic_prev;
		logic [CNT_W-1:0] ic_cnt;
		logic ic;
		logic [5:0] addr_n;
		logic cd_n;
		logic dir_n;
		logic sync_n;
		logic [15:0] dout_n;
		logic doe;
		logic [2:0] queue_n;
		req_kind_e kind;
		logic ack;
		logic [15:0] rdata;
		logic gv;
		logic [5:0] gsid;
		logic [7:0] gprio;
		logic gbad;
	} bus_s;

	bus_s r_reg;
	bus_s r_next;
	logic [2:0] req_act;
	logic [15:0] data_in;
	logic [5:0] sid_in;
	logic [2:0] ic_src;
	logic [2:0] ic_rise;
	logic queue_n_idle_chk;

	// Agreed pin levels, turned to active high
	assign req_act = ~r_reg.stab[DATA_LSB-1:REQ_LSB];
	assign data_in = ~r_reg.stab[SID_LSB-1:DATA_LSB];
	assign sid_in = ~r_reg.stab[ICS_LSB-1:SID_LSB];
	assign ic_src = r_reg.stab[SYN_W-1:ICS_LSB];
	assign ic_rise = ic_src & ~r_reg.ic_prev;
	// All three queue update lines idle, for the data drive check
	assign queue_n_idle_chk = &r_reg.queue_n;

	// Next state of the whole block
	always_comb begin
		r_next = r_reg;
		r_next.s1 = {master_clear_sw, power_restored, power_fail,
			source_ident_i_n, bus_data_i_n,
			service_irq_request_n, data_irq_request_n, dma_word_request_n};
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		// A bit moves only when second and third stages agree
		r_next.stab = (r_reg.s2 & r_reg.s3) |
			(r_reg.stab & (r_reg.s2 | r_reg.s3));
		// Free-running bus clock divider
		if (r_reg.div == DIV_W'(BUS_CLK_HALF - 1)) begin
			r_next.div = '0;
			r_next.clk_n = ~r_reg.clk_n;
		end else begin
			r_next.div = r_reg.div + 1'b1;
		end
		// Initial condition: level on power fail, stretched pulse otherwise
		r_next.ic_prev = ic_src;
		if (ic_rise[1] || ic_rise[2]) begin
			r_next.ic_cnt = CNT_W'(IC_CYC);
		end else if (r_reg.ic_cnt != '0) begin
			r_next.ic_cnt = r_reg.ic_cnt - 1'b1;
		end
		r_next.ic = ic_src[0] || (r_next.ic_cnt != '0);
		r_next.ack = 1'b0;
		r_next.gv = 1'b0;
		if (r_next.ic) begin
			// Clear drops every strobe so the bus goes quiet
			r_next.state = ST_IDLE;
			r_next.sync_n = 1'b1;
			r_next.doe = 1'b0;
			r_next.queue_n = QUEUE_IDLE;
		end else begin
			case (r_reg.state)
				ST_IDLE: begin
					if (io_req) begin
						r_next.addr_n = ~{io_instr[INSTR_ADDR_HI_MSB:INSTR_ADDR_HI_LSB],
							io_instr[INSTR_ADDR_LO_MSB:0]};
						r_next.cd_n = ~io_is_data;
						r_next.dir_n = ~io_is_input;
						r_next.dout_n = ~io_wdata;
						r_next.doe = ~io_is_input;
						r_next.cnt = CNT_W'(SETUP_CYC - 1);
						r_next.state = ST_SETUP;
					end else if (req_act != '0) begin
						// DMA first; data level C before service level D
						if (req_act[0]) begin
							r_next.kind = KIND_DMA;
							r_next.queue_n = 3'h6;
						end else if (req_act[1]) begin
							r_next.kind = KIND_DATA_IRQ;
							r_next.queue_n = 3'h5;
						end else begin
							r_next.kind = KIND_SERVICE_IRQ;
							r_next.queue_n = 3'h3;
						end
						r_next.cnt = CNT_W'(SETTLE_CYC - 1);
						r_next.state = ST_QUEUE;
					end
				end
				ST_SETUP: begin
					r_next.cnt = r_reg.cnt - 1'b1;
					if (r_reg.cnt == '0) begin
						r_next.sync_n = 1'b0;
						r_next.cnt = CNT_W'(SYNC_CYC - 1);
						r_next.state = ST_SYNC;
					end
				end
				ST_SYNC: begin
					r_next.cnt = r_reg.cnt - 1'b1;
					if (r_reg.cnt == '0) begin
						r_next.rdata = data_in;
						r_next.ack = 1'b1;
						r_next.sync_n = 1'b1;
						r_next.cnt = CNT_W'(SETUP_CYC - 1);
						r_next.state = ST_HOLD;
					end
				end
				ST_HOLD: begin
					// Address and data held past sync for the slowest receiver
					r_next.cnt = r_reg.cnt - 1'b1;
					if (r_reg.cnt == '0) begin
						r_next.doe = 1'b0;
						r_next.state = ST_IDLE;
					end
				end
				ST_QUEUE: begin
					// Losers have withdrawn by the end of the settle time
					r_next.cnt = r_reg.cnt - 1'b1;
					if (r_reg.cnt == '0) begin
						r_next.gsid = sid_in;
						r_next.gprio = data_in[PRIO_USED-1:0];
						r_next.gbad = |data_in[15:PRIO_USED];
						r_next.gv = 1'b1;
						r_next.queue_n = QUEUE_IDLE;
						r_next.cnt = CNT_W'(GAP_CYC - 1);
						r_next.state = ST_QGAP;
					end
				end
				ST_QGAP: begin
					// Wait for release and for the service to be finished
					if (r_reg.cnt != '0) begin
						r_next.cnt = r_reg.cnt - 1'b1;
					end else if (grant_done) begin
						r_next.state = ST_IDLE;
					end
				end
				default: begin
					r_next.state = ST_IDLE;
				end
			endcase
		end
	end

	// State register; ground-true bus lines rest at their inactive high level, initial condition asserted
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			r_reg <= '{state: ST_IDLE, cnt: '0, div: '0, clk_n: 1'b1,
				s1: SYN_RST, s2: SYN_RST, s3: SYN_RST, stab: SYN_RST,
				ic_prev: '0, ic_cnt: '0, ic: 1'b1, addr_n: '1, cd_n: 1'b1,
				dir_n: 1'b1, sync_n: 1'b1, dout_n: '1, doe: 1'b0,
				queue_n: QUEUE_IDLE, kind: KIND_DMA, ack: 1'b0, rdata: '0,
				gv: 1'b0, gsid: '0, gprio: '0, gbad: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs taken straight from the state register
	assign io_ack = r_reg.ack;
	assign io_rdata = r_reg.rdata;
	assign grant_valid = r_reg.gv;
	assign grant_kind = r_reg.kind;
	assign grant_source_id = r_reg.gsid;
	assign grant_prio = r_reg.gprio;
	assign grant_prio_unassigned = r_reg.gbad;
	assign dev_addr_n = r_reg.addr_n;
	assign cmd_or_data_sel_n = r_reg.cd_n;
	assign xfer_direction_n = r_reg.dir_n;
	assign xfer_sync_n = r_reg.sync_n;
	assign initial_condition = r_reg.ic;
	assign bus_clock_5m_n = r_reg.clk_n;
	assign bus_data_o_n = r_reg.dout_n;
	assign bus_data_oe = r_reg.doe;
	assign dma_queue_update_n = r_reg.queue_n[0];
	assign data_irq_queue_update_n = r_reg.queue_n[1];
	assign service_irq_queue_update_n = r_reg.queue_n[2];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_accept;
		r_reg.state == ST_IDLE && !r_next.ic && io_req;
	endsequence
	sequence s_qend;
		r_reg.state == ST_QUEUE && r_reg.cnt == '0 && !r_next.ic;
	endsequence

	// Address and function coding follow the accepted instruction
	addr_map_a: assert property (s_accept |=> dev_addr_n ==
		~{$past(io_instr[INSTR_ADDR_HI_MSB:INSTR_ADDR_HI_LSB]),
		$past(io_instr[INSTR_ADDR_LO_MSB:0])})
		else $error("device address not taken from instruction");
	func_code_a: assert property (s_accept |=>
		cmd_or_data_sel_n == !$past(io_is_data) &&
		xfer_direction_n == !$past(io_is_input))
		else $error("function lines wrongly coded");
	sync_stable_a: assert property (!xfer_sync_n && $past(!xfer_sync_n)
		|-> $stable(dev_addr_n) && $stable(cmd_or_data_sel_n) &&
		$stable(xfer_direction_n))
		else $error("address or function moved during sync");
	bus_clock_a: assert property ($rose(bus_clock_5m_n) |->
		bus_clock_5m_n[*5] ##1 !bus_clock_5m_n[*5])
		else $error("bus clock half period wrong");
	data_drive_a: assert property (bus_data_oe |-> xfer_direction_n &&
		queue_n_idle_chk)
		else $error("data bus driven outside an output transfer");
	grant_pulse_a: assert property (s_qend |=> grant_valid &&
		dma_queue_update_n ##1 !grant_valid)
		else $error("queue update did not end in one grant");
	prio_range_a: assert property (s_qend |=>
		grant_prio_unassigned == $past(|data_in[15:PRIO_USED]))
		else $error("unassigned priority not flagged");
	queue_order_a: assert property (r_reg.state == ST_IDLE && !r_next.ic &&
		!io_req && req_act[0] |=> !dma_queue_update_n &&
		data_irq_queue_update_n && service_irq_queue_update_n)
		else $error("DMA request not queued first");
	ic_master_a: assert property ($rose(ic_src[2]) |=>
		initial_condition[*8])
		else $error("master clear did not hold initial condition");
	ic_quiet_a: assert property (initial_condition |-> xfer_sync_n &&
		dma_queue_update_n && data_irq_queue_update_n &&
		service_irq_queue_update_n && !bus_data_oe)
		else $error("bus active during initial condition");

endmodule : io_party_line_bus
`default_nettype wire

// ---- io_party_line_bus_note_end.sv ----
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ---- ctl_model.sv ----
/*
 * Behavioural peripheral controller for the party-line bus.
 * Assumes the bench resolves every wired line as a wired-AND with pull-ups.
 */
`timescale 1ns/1ns
`default_nettype none
module ctl_model #(
	parameter logic [5:0] ADDR = 6'h00,
	parameter logic [5:0] SID = 6'h00
) (
	input wire logic [3:0] prio,
	input wire logic [2:0] want,
	input wire logic [15:0] status,
	input wire logic [5:0] dev_addr_n,
	input wire logic xfer_direction_n,
	input wire logic xfer_sync_n,
	input wire logic [2:0] queue_n,
	input wire logic initial_condition,
	input wire logic [15:0] bus_n,
	output logic [2:0] req_n,
	output logic [15:0] drive_n,
	output logic [5:0] sid_n
);
	logic queued;
	logic beaten;
	// Request lines are ground true; all dropped on initial condition
	assign req_n = initial_condition ? 3'h7 : ~want;
	// Answer a queue update of a pending kind
	assign queued = !initial_condition && |(want & ~queue_n);
	// A lower numbered line is the higher priority
	always_comb begin
		beaten = 1'b0;
		for (int i = 0; i < 16; i++)
			if (i < prio && !bus_n[i])
				beaten = 1'b1;
	end
	// Priority bit and identifier held while queued and not beaten
	always_comb begin
		drive_n = 16'hffff;
		sid_n = 6'h3f;
		if (queued && !beaten) begin
			drive_n[prio] = 1'b0;
			sid_n = ~SID;
		end else if (!initial_condition && !xfer_sync_n && !xfer_direction_n &&
			dev_addr_n == ~ADDR) begin
			drive_n = ~status;
		end
	end
endmodule : ctl_model
`default_nettype wire

// ---- test_io_party_line_bus.sv ----
/*
 * Self-checking bench for the processor end of the party-line bus.
 * Assumes two behavioural controllers and pull-ups on all wired lines.
 */
`timescale 1ns/1ns
`default_nettype none
module test_io_party_line_bus;
	import io_bus_pkg::*;
	localparam logic [5:0] ADDR_A = 6'h05;
	localparam logic [5:0] ADDR_B = 6'h2a;
	localparam logic [5:0] SID_A = 6'h11;
	localparam logic [5:0] SID_B = 6'h26;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic io_req = 1'b0;
	logic io_is_data = 1'b0;
	logic io_is_input = 1'b0;
	logic grant_done = 1'b0;
	logic power_fail = 1'b0;
	logic power_restored = 1'b0;
	logic master_clear_sw = 1'b0;
	logic [15:0] io_instr = 16'h0000;
	logic [15:0] io_wdata = 16'h0000;
	logic [2:0] want_a = 3'h0;
	logic [2:0] want_b = 3'h0;
	logic [3:0] pa = 4'h0;
	logic [3:0] pb = 4'h1;
	logic [15:0] sta, stb, io_rdata, bus_data_o_n, bus_data_i_n, da, db;
	logic [7:0] grant_prio;
	logic [5:0] grant_source_id, dev_addr_n, source_ident_i_n, sa, sb;
	logic [2:0] ra, rb, qn, qn_q;
	logic [1:0] grant_kind;
	logic io_ack, grant_valid, grant_prio_unassigned, cmd_or_data_sel_n;
	logic xfer_direction_n, xfer_sync_n, initial_condition, bus_clock_5m_n;
	logic bus_data_oe, dma_queue_update_n, data_irq_queue_update_n;
	logic service_irq_queue_update_n, dma_word_request_n, sync_q;
	logic data_irq_request_n, service_irq_request_n;
	logic [31:0] lfsr = 32'hc80e;
	logic [32:0] x;
	logic [16:0] g;
	logic [32:0] xq[$];
	logic [16:0] gq[$];
	int fails = 0;
	int checks = 0;
	time t;
	// Wired-AND with pull-ups: a released line reads high
	assign bus_data_i_n = (bus_data_oe ? bus_data_o_n : 16'hffff) & da & db;
	assign source_ident_i_n = sa & sb;
	assign {service_irq_request_n, data_irq_request_n,
		dma_word_request_n} = ra & rb;
	assign qn = {service_irq_queue_update_n, data_irq_queue_update_n,
		dma_queue_update_n};
	io_party_line_bus i_dut (.clk_sys, .rst_b, .io_req, .io_instr,
		.io_is_data, .io_is_input, .io_wdata, .io_ack, .io_rdata,
		.grant_valid, .grant_kind, .grant_source_id, .grant_prio,
		.grant_prio_unassigned, .grant_done, .power_fail, .power_restored,
		.master_clear_sw, .dev_addr_n, .cmd_or_data_sel_n, .xfer_direction_n,
		.xfer_sync_n, .initial_condition, .bus_clock_5m_n, .bus_data_i_n,
		.bus_data_o_n, .bus_data_oe, .dma_word_request_n, .data_irq_request_n,
		.service_irq_request_n, .dma_queue_update_n, .data_irq_queue_update_n,
		.service_irq_queue_update_n, .source_ident_i_n);
	ctl_model #(.ADDR(ADDR_A), .SID(SID_A)) i_ctl_a (.prio(pa), .want(want_a),
		.status(sta), .dev_addr_n, .xfer_direction_n, .xfer_sync_n,
		.initial_condition,
		.queue_n(qn), .bus_n(bus_data_i_n), .req_n(ra), .drive_n(da), .sid_n(sa));
	ctl_model #(.ADDR(ADDR_B), .SID(SID_B)) i_ctl_b (.prio(pb), .want(want_b),
		.status(stb), .dev_addr_n, .xfer_direction_n, .xfer_sync_n,
		.initial_condition,
		.queue_n(qn), .bus_n(bus_data_i_n), .req_n(rb), .drive_n(db), .sid_n(sb));
	// System clock at 50 MHz
	always #10 clk_sys = ~clk_sys;
	task automatic compare(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : compare
	task automatic end_sim;
		compare("left", 16'h0, 16'(gq.size() + xq.size()));
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// Next value of the random source
	function automatic void step();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
	endfunction : step
	// One programmed transfer; an input goes to a modelled controller
	task automatic xfer(input logic data, input logic inp);
		step();
		io_instr = lfsr[15:0];
		if (inp)
			{io_instr[9:8], io_instr[3:0]} = lfsr[16] ? ADDR_A : ADDR_B;
		io_wdata = lfsr[31:16];
		io_is_data = data;
		io_is_input = inp;
		xq.push_back({inp, ~{io_instr[9:8], io_instr[3:0], data, inp},
			8'h00, inp ? (lfsr[16] ? sta : stb) : io_wdata});
		io_req = 1'b1;
		repeat (60) begin
			@(negedge clk_sys);
			if (io_ack === 1'b1)
				break;
		end
		io_req = 1'b0;
		repeat (6) @(negedge clk_sys);
	endtask : xfer
	// Raise requests, then release each winner after its grant
	task automatic arb(input logic [2:0] wa, input logic [2:0] wb);
		int k;
		logic win_a;
		logic [3:0] p;
		want_a = wa;
		want_b = wb;
		while ((want_a | want_b) != 3'h0) begin
			k = (want_a[0] | want_b[0]) ? 0 : (want_a[1] | want_b[1]) ? 1 : 2;
			win_a = want_a[k] && (!want_b[k] || pa < pb);
			p = win_a ? pa : pb;
			gq.push_back({2'(k), win_a ? SID_A : SID_B, 8'(16'h1 << p), p > 7});
			repeat (120) begin
				@(negedge clk_sys);
				if (grant_valid === 1'b1)
					break;
			end
			if (win_a)
				want_a[k] = 1'b0;
			else
				want_b[k] = 1'b0;
			repeat (12) @(negedge clk_sys);
			grant_done = 1'b1;
			@(negedge clk_sys);
			grant_done = 1'b0;
		end
	endtask : arb
	// Compare each result against the oldest note
	always @(negedge clk_sys) begin
		sync_q <= xfer_sync_n;
		qn_q <= qn;
		if (sync_q === 1'b1 && xfer_sync_n === 1'b0 && xq.size() > 0) begin
			x = xq[0];
			compare("pins", {8'h0, x[31:24]}, {8'h0, dev_addr_n,
				cmd_or_data_sel_n, xfer_direction_n});
			compare("oe", {15'h0, !x[32]}, {15'h0, bus_data_oe});
			if (!x[32])
				compare("wdata", ~x[15:0], bus_data_o_n);
		end
		if (io_ack === 1'b1) begin
			x = xq.pop_front();
			compare("pins_end", {8'h0, x[31:24]}, {8'h0, dev_addr_n,
				cmd_or_data_sel_n, xfer_direction_n});
			if (x[32])
				compare("rdata", x[15:0], io_rdata);
		end
		if (qn_q === 3'h7 && qn !== 3'h7 && gq.size() > 0)
			compare("queue", {13'h0, ~(3'h1 << gq[0][16:15])},
				{13'h0, qn});
		if (grant_valid === 1'b1) begin
			g = gq.pop_front();
			compare("kind_sid", {8'h0, g[16:9]},
				{8'h0, grant_kind, grant_source_id});
			compare("prio", {7'h0, g[8:0]},
				{7'h0, grant_prio, grant_prio_unassigned});
		end
	end
	// Main sequence
	initial begin
		sta = 16'h0000;
		stb = 16'h0000;
		repeat (10) @(negedge clk_sys);
		compare("ic_reset", 16'h1, {15'h0, initial_condition});
		compare("sync_idle", 16'h1, {15'h0, xfer_sync_n});
		rst_b = 1'b1;
		step();
		sta = lfsr[15:0];
		stb = lfsr[31:16];
		@(posedge bus_clock_5m_n);
		t = $time;
		@(negedge bus_clock_5m_n);
		compare("clk_high", 16'd100, 16'($time - t));
		@(posedge bus_clock_5m_n);
		compare("clk_period", 16'd200, 16'($time - t));
		@(negedge clk_sys);
		compare("ic_off", 16'h0, {15'h0, initial_condition});
		for (int i = 0; i < 8; i++)
			xfer(i[1], i[0]);
		for (int k = 0; k < 4; k++) begin
			step();
			pa = {1'b0, lfsr[2:0]};
			pb = {1'b0, lfsr[2:0] ^ 3'(1 + lfsr[4:3])};
			arb(k < 3 ? 3'h1 << k : 3'h4, k < 3 ? 3'h1 << k : 3'h1);
		end
		pb = 4'd12;
		arb(3'h2, 3'h2);
		for (int s = 0; s < 3; s++) begin
			{master_clear_sw, power_restored, power_fail} = 3'h1 << s;
			repeat (10) @(negedge clk_sys);
			compare("ic_on", 16'h1, {15'h0, initial_condition});
			{master_clear_sw, power_restored, power_fail} = 3'h0;
			repeat (520) @(negedge clk_sys);
			compare("ic_end", 16'h0, {15'h0, initial_condition});
		end
		end_sim();
	end
	// Watchdog well beyond the expected run
	initial begin
		#200000;
		fails++;
		end_sim();
	end
endmodule : test_io_party_line_bus
`default_nettype wire
